// File: include/sdis_map.vh
// register offsets, field positions, reset values and timing for sdis
`ifndef SDIS_MAP_VH
`define SDIS_MAP_VH
`define SDIS_OFS_OUTCTL 8'h10
`define SDIS_OFS_STATUS 8'h11
`define SDIS_OFS_SRCOVR 8'h12
`define SDIS_OFS_IRQST 8'h13
`define SDIS_OFS_IRQMSK 8'h14
`define SDIS_OUTCTL_RST 8'h30
`define SDIS_SRCOVR_RST 8'h01
`define SDIS_B_OUTPUT_CLOCK_POLARITY_BIT 7
`define SDIS_B_PIX 6
`define SDIS_B_DRVH 5
`define SDIS_B_DRVL 4
`define SDIS_B_TRI 3
`define SDIS_B_SDPOL 2
`define SDIS_B_HSDET 7
`define SDIS_B_SGDET 6
`define SDIS_B_VSDET 5
`define SDIS_B_CKDET 4
`define SDIS_B_AI 3
`define SDIS_B_AHS 2
`define SDIS_B_AVS 1
`define SDIS_B_SEEK 0
`define SDIS_B_AIO 7
`define SDIS_B_AIS 6
`define SDIS_B_AHO 5
`define SDIS_B_AHSEL 4
`define SDIS_B_AVO 3
`define SDIS_B_AVSEL 2
`define SDIS_WINDOW_US 100
`define SDIS_CLK_MHZ 100
`define SDIS_WINDOW_CYC (`SDIS_WINDOW_US * `SDIS_CLK_MHZ)
`endif

// File: hw/sdis_top.v
// sync detect, interface select and output control register bank
`timescale 1ns/1ns
`include "sdis_map.vh"
module sdis_top #(
	parameter WINDOW_CYC = `SDIS_WINDOW_CYC
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// register port
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	output reg [7:0] rdata_q,
	// activity inputs from pins
	input wire hsync_in,
	input wire sync_on_green_input,
	input wire vsync_in,
	input wire dig_clk_in,
	// output control
	output wire output_clock_polarity_bit,
	output wire two_pix_per_clk,
	output wire [1:0] drive_level,
	output wire out_drive_en,
	output wire odd_port_en,
	output wire output_tristate_bit,
	output wire sync_detect_pin,
	output wire seek_mode,
	output wire chosen_interface_flag,
	output wire chosen_hsync_source,
	output wire chosen_vsync_source,
	// interrupt
	output wire irq
);
	reg [7:0] outctl_q;
	reg [7:0] srcovr_q;
	reg [7:0] irqst_q;
	reg [7:0] irqmsk_q;
	wire [3:0] pin_in;
	wire [3:0] det;
	reg [3:0] det_prev_q;
	reg [7:0] stat_d;
	assign pin_in = {hsync_in, sync_on_green_input, vsync_in, dig_clk_in};

	// one detector per input: hsync, sog, vsync, digital clock
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_det
			reg [2:0] sy_q;
			reg [31:0] quiet_q;
			reg [31:0] quiet_d;
			reg act_q;
			reg act_d;
			wire edge_seen;
			// first stage feeds only the second
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sy_q <= 3'h0;
				end else begin
					sy_q <= {sy_q[1:0], pin_in[g]};
				end
			end
			// a steady level, high or low, is no activity
			assign edge_seen = sy_q[2] != sy_q[1];
			// quiet counter stops at the window end, no wrap back to busy
			always @* begin
				quiet_d = quiet_q;
				act_d = act_q;
				if (edge_seen) begin
					quiet_d = 32'h0;
					act_d = 1'h1;
				end else if (quiet_q >= WINDOW_CYC - 1) begin
					act_d = 1'h0;
				end else begin
					quiet_d = quiet_q + 32'h1;
				end
			end
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					quiet_q <= 32'h0;
					act_q <= 1'h0;
				end else begin
					quiet_q <= quiet_d;
					act_q <= act_d;
				end
			end
			assign det[g] = act_q;
		end
	endgenerate

	// det[3]=hsync [2]=sog [1]=vsync [0]=clock
	wire hs_det = det[3];
	wire sg_det = det[2];
	wire vs_det = det[1];
	wire ck_det = det[0];
	wire an_act = hs_det | sg_det | vs_det;
	wire interface_preference_bit = srcovr_q[`SDIS_B_AIS];
	wire ahsel = srcovr_q[`SDIS_B_AHSEL];
	reg ai_sel;
	reg ahs_sel;
	reg avs_sel;
	always @* begin
		// seek mode when nothing active and no interface override; flag held at preference then
		if (srcovr_q[`SDIS_B_AIO]) begin
			ai_sel = interface_preference_bit;
		end else if (an_act && ck_det) begin
			ai_sel = interface_preference_bit;
		end else if (ck_det) begin
			ai_sel = 1'b1;
		end else if (an_act) begin
			ai_sel = 1'b0;
		end else begin
			ai_sel = interface_preference_bit;
		end
		if (srcovr_q[`SDIS_B_AHO]) begin
			ahs_sel = ahsel;
		end else if (sg_det != hs_det) begin
			ahs_sel = sg_det;
		end else begin
			ahs_sel = ahsel;
		end
		if (srcovr_q[`SDIS_B_AVO]) begin
			avs_sel = srcovr_q[`SDIS_B_AVSEL];
		end else begin
			avs_sel = vs_det;
		end
		stat_d = {hs_det, sg_det, vs_det, ck_det, ai_sel, ahs_sel,
			avs_sel, seek_mode};
	end
	assign seek_mode = ~srcovr_q[`SDIS_B_AIO] & ~an_act & ~ck_det;
	assign chosen_interface_flag = ai_sel;
	assign chosen_hsync_source = ahs_sel;
	assign chosen_vsync_source = avs_sel;

	// output control decode
	assign output_clock_polarity_bit = outctl_q[`SDIS_B_OUTPUT_CLOCK_POLARITY_BIT] & ai_sel;
	assign two_pix_per_clk = outctl_q[`SDIS_B_PIX];
	// 11 high, 10 medium, 0x low (00)
	reg [1:0] drive_sel;
	always @* begin
		case (outctl_q[`SDIS_B_DRVH:`SDIS_B_DRVL])
		2'h3: begin
			drive_sel = 2'h3;
		end
		2'h2: begin
			drive_sel = 2'h2;
		end
		default: begin
			drive_sel = 2'h0;
		end
		endcase
	end
	assign drive_level = drive_sel;
	assign output_tristate_bit = outctl_q[`SDIS_B_TRI];
	assign out_drive_en = ~outctl_q[`SDIS_B_TRI];
	// odd port idles in one-pixel mode on the digital side
	assign odd_port_en = ~outctl_q[`SDIS_B_TRI] &
		(~ai_sel | outctl_q[`SDIS_B_PIX]);
	assign sync_detect_pin = (an_act | ck_det) ^
		outctl_q[`SDIS_B_SDPOL];
	assign irq = |(irqst_q & irqmsk_q);

	// address decode of the register port
	wire hit_outctl;
	wire hit_status;
	wire hit_srcovr;
	wire hit_irqst;
	wire hit_irqmsk;
	assign hit_outctl = addr == `SDIS_OFS_OUTCTL;
	assign hit_status = addr == `SDIS_OFS_STATUS;
	assign hit_srcovr = addr == `SDIS_OFS_SRCOVR;
	assign hit_irqst = addr == `SDIS_OFS_IRQST;
	assign hit_irqmsk = addr == `SDIS_OFS_IRQMSK;

	// status is read only, so it has no write enable
	wire wr_outctl;
	wire wr_srcovr;
	wire wr_irqmsk;
	wire rd_irqst;
	assign wr_outctl = wr_stb & hit_outctl;
	assign wr_srcovr = wr_stb & hit_srcovr;
	assign wr_irqmsk = wr_stb & hit_irqmsk;
	assign rd_irqst = rd_stb & hit_irqst;

	// detector edges, either direction, raise an event
	wire [3:0] det_chg;
	assign det_chg = det ^ det_prev_q;

	// next values
	reg [7:0] outctl_d;
	reg [7:0] srcovr_d;
	reg [7:0] irqmsk_d;
	reg [7:0] irqst_d;
	reg [7:0] rdata_d;

	// low two bits unused, kept zero so reads stay clean
	always @* begin
		outctl_d = outctl_q;
		if (wr_outctl) begin
			outctl_d = {wdata[7:2], 2'h0};
		end
	end

	// power-down bit 0 is stored only, nothing here acts on it
	always @* begin
		srcovr_d = srcovr_q;
		if (wr_srcovr) begin
			srcovr_d = wdata;
		end
	end

	// only the four event bits exist
	always @* begin
		irqmsk_d = irqmsk_q;
		if (wr_irqmsk) begin
			irqmsk_d = {wdata[7:4], 4'h0};
		end
	end

	// a new edge wins over the read clear, so none is lost
	always @* begin
		irqst_d = irqst_q;
		if (rd_irqst) begin
			irqst_d = 8'h0;
		end
		irqst_d = irqst_d | {det_chg, 4'h0};
	end

	// read data stands one cycle, zero otherwise
	always @* begin
		rdata_d = 8'h0;
		if (rd_stb) begin
			case (addr)
			`SDIS_OFS_OUTCTL: begin
				rdata_d = outctl_q;
			end
			`SDIS_OFS_STATUS: begin
				rdata_d = stat_d;
			end
			`SDIS_OFS_SRCOVR: begin
				rdata_d = srcovr_q;
			end
			`SDIS_OFS_IRQST: begin
				rdata_d = irqst_q;
			end
			`SDIS_OFS_IRQMSK: begin
				rdata_d = irqmsk_q;
			end
			default: begin
				rdata_d = 8'h0;
			end
			endcase
		end
	end

	// output and format control
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			outctl_q <= `SDIS_OUTCTL_RST;
		end else begin
			outctl_q <= outctl_d;
		end
	end

	// source override control
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			srcovr_q <= `SDIS_SRCOVR_RST;
		end else begin
			srcovr_q <= srcovr_d;
		end
	end

	// event mask
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irqmsk_q <= 8'h0;
		end else begin
			irqmsk_q <= irqmsk_d;
		end
	end

	// sticky events
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irqst_q <= 8'h0;
		end else begin
			irqst_q <= irqst_d;
		end
	end

	// detector history, reset matches idle so no false event
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			det_prev_q <= 4'h0;
		end else begin
			det_prev_q <= det;
		end
	end

	// read port
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end
endmodule // sdis_top

// File: sim/sdis_src_model.sv
// video source model driving the sync and clock pins
`timescale 1ns/1ns
module sdis_src_model (
	// clock and pin enables
	input wire clock,
	input wire [3:0] en,
	// pins toward the receiver
	output logic [3:0] pins
);
	logic [1:0] div_q = 2'h0;
	initial pins = 4'h0;
	// a disabled pin holds its level, which counts as idle
	always @(posedge clock) begin
		div_q <= div_q + 2'h1;
		if (div_q == 2'h0)
			pins <= pins ^ en;
	end
endmodule // sdis_src_model

// File: sim/sdis_top_asserts.sv
// port assertions for the sdis register bank
`timescale 1ns/1ns
module sdis_chk (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// activity pins
	input wire hsync_in,
	input wire sync_on_green_input,
	input wire vsync_in,
	input wire dig_clk_in,
	// outputs
	input wire output_clock_polarity_bit,
	input wire two_pix_per_clk,
	input wire out_drive_en,
	input wire odd_port_en,
	input wire output_tristate_bit,
	input wire seek_mode,
	input wire chosen_interface_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_tri_drive: assert property (
		out_drive_en != output_tristate_bit) else $error("drive enable");
	a_tri_odd: assert property (
		output_tristate_bit |-> !odd_port_en) else $error("odd not off");
	a_pol_dig: assert property (
		output_clock_polarity_bit |-> chosen_interface_flag)
		else $error("clock invert on analog");
	a_odd_two: assert property (
		chosen_interface_flag && out_drive_en |->
		odd_port_en == two_pix_per_clk) else $error("odd port wrong");
	a_hs_wake: assert property (
		$changed(hsync_in) |-> ##[1:8] !seek_mode) else $error("hs idle");
	a_sg_wake: assert property (
		$changed(sync_on_green_input) |-> ##[1:8] !seek_mode)
		else $error("sog idle");
	a_vs_wake: assert property (
		$changed(vsync_in) |-> ##[1:8] !seek_mode) else $error("vs idle");
	a_ck_wake: assert property (
		$changed(dig_clk_in) |-> ##[1:8] !seek_mode) else $error("ck idle");
	c_wake: cover property ($fell(seek_mode));
	c_two: cover property (odd_port_en && two_pix_per_clk);
	c_tri: cover property ($rose(output_tristate_bit));
endmodule // sdis_chk
bind sdis_top sdis_chk u_chk (.clock(clock), .rst_n(rst_n),
	.hsync_in(hsync_in), .sync_on_green_input(sync_on_green_input),
	.vsync_in(vsync_in), .dig_clk_in(dig_clk_in),
	.output_clock_polarity_bit(output_clock_polarity_bit),
	.two_pix_per_clk(two_pix_per_clk), .out_drive_en(out_drive_en),
	.odd_port_en(odd_port_en), .output_tristate_bit(output_tristate_bit),
	.seek_mode(seek_mode), .chosen_interface_flag(chosen_interface_flag));

// File: sim/test_sdis_top.sv
// self-checking bench for the sdis register bank
`timescale 1ns/1ns
module test_sdis_top;
	logic clock = 0, rst_n = 0, wr_stb = 0, rd_stb = 0;
	logic [7:0] addr = 0, wdata = 0, rv, oc, so;
	logic [3:0] act = 0;
	wire [3:0] p;
	wire [7:0] rd;
	wire [12:0] y;
	int bad_count = 0, compares = 0, seed = 32'h03b35f6d;
	always #5 clock = ~clock;
	sdis_src_model u_src (.clock(clock), .en(act), .pins(p));
	sdis_top #(.WINDOW_CYC(16)) u_dut (.clock(clock), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata_q(rd), .hsync_in(p[3]), .sync_on_green_input(p[2]),
		.vsync_in(p[1]), .dig_clk_in(p[0]), .output_clock_polarity_bit(y[9]),
		.two_pix_per_clk(y[8]), .drive_level(y[7:6]), .out_drive_en(y[5]),
		.odd_port_en(y[12]), .output_tristate_bit(y[4]),
		.sync_detect_pin(y[3]), .seek_mode(y[2]),
		.chosen_interface_flag(y[1]), .chosen_hsync_source(y[11]),
		.chosen_vsync_source(y[10]), .irq(y[0]));
	task chk(input logic [12:0] s, e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1;
		@(posedge clock);
		wr_stb <= 0;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1;
		@(posedge clock);
		rd_stb <= 0;
		#1;
		rv = rd;
	endtask
	// status from pin activity and override settings
	function logic [7:0] st_exp(input logic [3:0] a, input logic [7:0] s);
		logic an;
		an = |a[3:1];
		return {a, (s[7] | an == a[0]) ? s[6] : a[0],
			(s[5] | a[3] == a[2]) ? s[4] : a[2], s[3] ? s[2] : a[1],
			!(an | a[0] | s[7])};
	endfunction
	function logic [12:0] y_exp(input logic [7:0] c, st);
		return {!c[3] & (!st[3] | c[6]), st[2], st[1],
			c[7] & st[3], c[6], c[5] ? c[5:4] : 2'b00, !c[3], c[3],
			(|st[7:4]) ^ c[2], st[0], st[3], 1'b0};
	endfunction
	task print_verdict;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1;
		rd_reg(8'h10);
		chk(rv, 8'h30);
		rd_reg(8'h12);
		chk(rv, 8'h01);
		wr(8'h11, 8'hff);
		rd_reg(8'h20);
		chk(rv, 8'h00);
		rd_reg(8'h11);
		chk(rv, 8'h01);
		chk(y, y_exp(8'h30, 8'h01));
		$display("test done: reset");
		wr(8'h14, 8'h80);
		act <= 4'h8;
		step(12);
		chk(y[0], 1'b1);
		rd_reg(8'h13);
		chk(rv, 8'h80);
		chk(y[0], 1'b0);
		wr(8'h14, 8'h00);
		act <= 4'h0;
		step(40);
		chk(y[0], 1'b0);
		rd_reg(8'h13);
		chk(rv, 8'h80);
		$display("test done: interrupt");
		repeat (30) begin
			oc = $random(seed);
			so = $random(seed) | 1;
			wr(8'h10, oc);
			wr(8'h12, so);
			act <= $random(seed);
			step(40);
			rd_reg(8'h10);
			chk(rv, oc & 8'hfc);
			rd_reg(8'h11);
			chk(rv, st_exp(act, so));
			chk(y, y_exp(oc, st_exp(act, so)));
		end
		$display("test done: random");
		print_verdict;
	end
endmodule // test_sdis_top
